// file: amead_decoder.v
// Addressing-mode effective address decoder
`include "amead_regs.vh"
`timescale 1ns/1ps
module amead_decoder #(
   parameter W = 32
) (
   input  wire           CLK,
   input  wire           RST_B,
   input  wire           START,
   input  wire [4:0]     MODE,
   input  wire           OPERAND_WRITTEN,
   input  wire [W-1:0]   FIRST_DISPLACEMENT,
   input  wire [W-1:0]   SECOND_DISPLACEMENT,
   input  wire [8*W-1:0] GENERAL_REGS,
   input  wire [W-1:0]   FRAME_BASE_POINTER,
   input  wire [W-1:0]   INTERRUPT_STACK_POINTER,
   input  wire [W-1:0]   USER_STACK_POINTER,
   input  wire [W-1:0]   STATIC_BASE_POINTER,
   input  wire [W-1:0]   LINK_TABLE_BASE,
   input  wire [15:0]    PROCESSOR_STATUS_WORD,
   input  wire [W-1:0]   QUEUE_DATA,
   input  wire           QUEUE_VALID,
   output wire           QUEUE_TAKE,
   output wire           MEM_REQ,
   output reg  [W-1:0]   MEM_ADDR,
   input  wire           MEM_ACK,
   input  wire [W-1:0]   MEM_RDATA,
   output wire           BUSY,
   output reg            DONE,
   output reg            ILLEGAL_MODE,
   output reg            OPERAND_IN_REG,
   output reg  [2:0]     OPERAND_REG_NUM,
   output reg            OPERAND_IMMEDIATE,
   output reg  [W-1:0]   OPERAND_VALUE,
   output wire [W-1:0]   EFFECTIVE_ADDRESS
);
   // One-hot sequencer states: idle, first sum, pointer read, queue wait, finish
   localparam [4:0] S_IDLE = 5'b00001;
   localparam [4:0] S_ADD  = 5'b00010;
   localparam [4:0] S_PTR  = 5'b00100;
   localparam [4:0] S_IMM  = 5'b01000;
   localparam [4:0] S_FIN  = 5'b10000;

   // Sequencer state, adder operands, selected bases and mode classes
   reg  [4:0]   state_q;
   reg  [4:0]   state_d;
   reg  [W-1:0] add_a;
   reg  [W-1:0] add_b;
   reg          add_load;
   reg  [W-1:0] base_sel;
   reg  [W-1:0] stack_sel;
   reg  [W-1:0] reg_sel;
   wire [W-1:0] link_off;
   wire         mem_rel;
   wire         is_reg;
   wire         is_rsv;
   wire         is_imm;
   wire         is_abs;
   wire         is_link;
   wire         take_start;
   wire         take_queue;

   // Mode classes decoded from the five-bit field
   assign mem_rel  = (MODE == `AMEAD_MODE_FRAME_MR) || (MODE == `AMEAD_MODE_STACK_MR) ||
                     (MODE == `AMEAD_MODE_STATIC_MR);
   assign is_reg   = (MODE[4:3] == `AMEAD_MODE_REG_HI);
   assign is_rsv   = (MODE == `AMEAD_MODE_RESERVED);
   assign is_imm   = (MODE == `AMEAD_MODE_IMMEDIATE);
   assign is_abs   = (MODE == `AMEAD_MODE_ABSOLUTE);
   assign is_link  = (MODE == `AMEAD_MODE_LINK);

   // Link entries are one word apart, so the index is scaled to bytes
   assign link_off = FIRST_DISPLACEMENT << `AMEAD_LINK_ENTRY_SH;

   // Accepted start and queue hand-over events
   assign take_start = (state_q == S_IDLE) && START;
   assign take_queue = (state_q == S_IMM) && QUEUE_VALID;

   // Stack pointer chosen by status-word select bit
   always @* begin
      stack_sel = PROCESSOR_STATUS_WORD[`AMEAD_SSEL_BIT] ? USER_STACK_POINTER
                                                         : INTERRUPT_STACK_POINTER;
      reg_sel   = GENERAL_REGS[MODE[2:0]*W +: W];
      case (MODE)
         `AMEAD_MODE_FRAME_MR:  base_sel = FRAME_BASE_POINTER;
         `AMEAD_MODE_STACK_MR:  base_sel = stack_sel;
         `AMEAD_MODE_STATIC_MR: base_sel = STATIC_BASE_POINTER;
         default:               base_sel = reg_sel;
      endcase
   end

   // Adder operand selection per state and mode
   always @* begin
      add_a    = {W{1'b0}};
      add_b    = {W{1'b0}};
      add_load = 1'b0;
      case (state_q)
         S_IDLE: begin
            if (START && MODE[4:3] == `AMEAD_MODE_RELREG_HI) begin
               add_a    = reg_sel;
               add_b    = FIRST_DISPLACEMENT;
               add_load = 1'b1;
            end else if (START && mem_rel) begin
               add_a    = base_sel;
               add_b    = FIRST_DISPLACEMENT;
               add_load = 1'b1;
            end else if (START && is_abs) begin
               add_b    = FIRST_DISPLACEMENT;
               add_load = 1'b1;
            end else if (START && is_link) begin
               add_a    = LINK_TABLE_BASE;
               add_b    = link_off;
               add_load = 1'b1;
            end
         end
         S_PTR: begin
            if (MEM_ACK) begin
               add_a    = MEM_RDATA;
               add_b    = SECOND_DISPLACEMENT;
               add_load = 1'b1;
            end
         end
         default: begin
            add_load = 1'b0;
         end
      endcase
   end

   // Shared adder forms every address sum
   amead_adder #(.W(W)) u_adder (
      .clk   (CLK),
      .rst_b (RST_B),
      .load  (add_load),
      .a     (add_a),
      .b     (add_b),
      .sum_q (EFFECTIVE_ADDRESS)
   );

   // Next-state logic
   always @* begin
      state_d = state_q;
      case (state_q)
         S_IDLE: begin
            if (START) begin
               if (MODE == `AMEAD_MODE_RESERVED) begin
                  state_d = S_FIN;
               end else if (MODE == `AMEAD_MODE_IMMEDIATE) begin
                  state_d = OPERAND_WRITTEN ? S_FIN : S_IMM;
               end else if (mem_rel || is_link) begin
                  state_d = S_ADD;
               end else begin
                  state_d = S_FIN;
               end
            end
         end
         S_ADD:   state_d = S_PTR;
         S_PTR:   state_d = MEM_ACK ? S_FIN : S_PTR;
         S_IMM:   state_d = QUEUE_VALID ? S_FIN : S_IMM;
         S_FIN:   state_d = S_IDLE;
         default: state_d = S_IDLE;
      endcase
   end

   // Handshake and status outputs follow the state
   assign MEM_REQ    = (state_q == S_PTR);
   assign QUEUE_TAKE = take_queue;
   assign BUSY       = (state_q != S_IDLE);

   // State register
   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_q <= S_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Completion pulse, one cycle after the finish state
   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         DONE <= 1'b0;
      end else begin
         DONE <= (state_q == S_FIN);
      end
   end

   // Pointer fetch address, captured once the first sum stands
   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         MEM_ADDR <= `AMEAD_ADDR_RST;
      end else if (state_q == S_ADD) begin
         MEM_ADDR <= EFFECTIVE_ADDRESS;
      end
   end

   // Immediate operand taken from the queue
   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         OPERAND_VALUE <= `AMEAD_ADDR_RST;
      end else if (take_queue) begin
         OPERAND_VALUE <= QUEUE_DATA;
      end
   end

   // Operand location flags, held until the next start
   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         OPERAND_IN_REG    <= 1'b0;
         OPERAND_REG_NUM   <= 3'h0;
         OPERAND_IMMEDIATE <= 1'b0;
      end else if (take_start) begin
         OPERAND_IN_REG    <= is_reg;
         OPERAND_REG_NUM   <= MODE[2:0];
         OPERAND_IMMEDIATE <= is_imm && !OPERAND_WRITTEN;
      end
   end

   // Illegal mode flag for the exception logic, held until the next start
   always @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         ILLEGAL_MODE <= 1'b0;
      end else if (take_start) begin
         ILLEGAL_MODE <= is_rsv || (is_imm && OPERAND_WRITTEN);
      end
   end
endmodule

// file: amead_regs.vh
// Mode encodings and constants for the addressing-mode decoder
`ifndef AMEAD_REGS_VH
`define AMEAD_REGS_VH
`define AMEAD_MODE_REG_HI    2'b00
`define AMEAD_MODE_RELREG_HI 2'b01
`define AMEAD_MODE_FRAME_MR  5'h10
`define AMEAD_MODE_STACK_MR  5'h11
`define AMEAD_MODE_STATIC_MR 5'h12
`define AMEAD_MODE_RESERVED  5'h13
`define AMEAD_MODE_IMMEDIATE 5'h14
`define AMEAD_MODE_ABSOLUTE  5'h15
`define AMEAD_MODE_LINK      5'h16
`define AMEAD_LINK_ENTRY_SH  2
`define AMEAD_SSEL_BIT       9
`define AMEAD_ADDR_RST       32'h00000000
`endif

// file: amead_adder.v
// Registered address adder shared by all address-forming steps
`timescale 1ns/1ps
module amead_adder #(
   parameter W = 32
) (
   input  wire         clk,
   input  wire         rst_b,
   input  wire         load,
   input  wire [W-1:0] a,
   input  wire [W-1:0] b,
   output reg  [W-1:0] sum_q
);
   // Sum captured on load, held otherwise
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sum_q <= {W{1'b0}};
      end else if (load) begin
         sum_q <= a + b;
      end
   end
endmodule

// file: amead_sva.sv
// Port assertions for the addressing-mode decoder
`timescale 1ns/1ps
module amead_sva #(parameter W = 32) (
   input wire         CLK,
   input wire         RST_B,
   input wire         START,
   input wire         BUSY,
   input wire         DONE,
   input wire         ILLEGAL_MODE,
   input wire         MEM_REQ,
   input wire         MEM_ACK,
   input wire         OPERAND_WRITTEN,
   input wire         OPERAND_IN_REG,
   input wire         OPERAND_IMMEDIATE,
   input wire         QUEUE_TAKE,
   input wire         QUEUE_VALID,
   input wire [4:0]   MODE,
   input wire [2:0]   OPERAND_REG_NUM,
   input wire [W-1:0] EFFECTIVE_ADDRESS,
   input wire [W-1:0] FIRST_DISPLACEMENT
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   // Accepted request of one mode, and the memory answer
   sequence s_go(m); START && !BUSY && m; endsequence
   sequence s_ack; MEM_REQ && MEM_ACK; endsequence
   AST_REG: assert property (s_go(MODE[4:3] == 2'b00) |-> ##2 DONE && OPERAND_IN_REG
      && {2'b00, OPERAND_REG_NUM} == $past(MODE, 2)) else $error("register operand wrong");
   AST_RR: assert property (s_go(MODE[4:3] == 2'b01) |-> ##2 DONE && !ILLEGAL_MODE && !OPERAND_IN_REG)
      else $error("register relative wrong");
   AST_MR: assert property (s_go(MODE inside {5'h10, 5'h11, 5'h12, 5'h16}) |-> ##2 MEM_REQ)
      else $error("no pointer read");
   AST_ACK: assert property (s_ack |=> !MEM_REQ ##1 DONE)
      else $error("pointer step not closed");
   AST_RSV: assert property (s_go(MODE == 5'h13) |-> ##2 DONE && ILLEGAL_MODE)
      else $error("reserved mode accepted");
   AST_IMMW: assert property (s_go(MODE == 5'h14 && OPERAND_WRITTEN) |-> ##2 DONE && ILLEGAL_MODE)
      else $error("written immediate accepted");
   AST_IMM: assert property (QUEUE_TAKE |-> QUEUE_VALID && !ILLEGAL_MODE ##2 DONE && OPERAND_IMMEDIATE)
      else $error("immediate take wrong");
   AST_ABS: assert property (s_go(MODE == 5'h15) |-> ##2 EFFECTIVE_ADDRESS == $past(FIRST_DISPLACEMENT, 2))
      else $error("absolute address wrong");
endmodule
bind amead_decoder amead_sva #(.W(W)) chk_u (
   .CLK                (CLK),
   .RST_B              (RST_B),
   .START              (START),
   .BUSY               (BUSY),
   .DONE               (DONE),
   .ILLEGAL_MODE       (ILLEGAL_MODE),
   .MEM_REQ            (MEM_REQ),
   .MEM_ACK            (MEM_ACK),
   .OPERAND_WRITTEN    (OPERAND_WRITTEN),
   .OPERAND_IN_REG     (OPERAND_IN_REG),
   .OPERAND_IMMEDIATE  (OPERAND_IMMEDIATE),
   .QUEUE_TAKE         (QUEUE_TAKE),
   .QUEUE_VALID        (QUEUE_VALID),
   .MODE               (MODE),
   .OPERAND_REG_NUM    (OPERAND_REG_NUM),
   .EFFECTIVE_ADDRESS  (EFFECTIVE_ADDRESS),
   .FIRST_DISPLACEMENT (FIRST_DISPLACEMENT)
);

// file: amead_far.sv
// Far-side model: operand memory and instruction queue
`timescale 1ns/1ps
module amead_far (
   input  wire        clk,
   input  wire        rst_b,
   input  wire        mem_req,
   input  wire [2:0]  slow,
   input  wire [31:0] mem_addr,
   input  wire [31:0] imm,
   output reg         mem_ack,
   output reg         queue_valid,
   output wire [31:0] mem_rdata,
   output wire [31:0] queue_data
);
   reg [2:0] w_q;
   // Data stands only while valid; otherwise the inverse shows
   assign mem_rdata = mem_ack ? mem_addr ^ 32'h5a5a0f0f : ~(mem_addr ^ 32'h5a5a0f0f);
   assign queue_data = queue_valid ? imm : ~imm;
   // One-cycle acknowledge after slow wait cycles; queue empty every other cycle
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         w_q <= 3'h0;
         mem_ack <= 1'b0;
         queue_valid <= 1'b0;
      end else begin
         mem_ack <= mem_req && !mem_ack && w_q == slow;
         w_q <= (mem_req && !mem_ack) ? w_q + 3'h1 : 3'h0;
         queue_valid <= ~queue_valid;
      end
   end
endmodule

// file: amead_decoder_tb.sv
// Self-checking bench for the addressing-mode decoder
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module amead_decoder_tb;
   reg         clk = 0, rst_b = 0, start = 0, ow = 0;
   reg [2:0]   slow = 0;
   reg [4:0]   mode = 0;
   reg [15:0]  psw = 0;
   reg [31:0]  d1 = 0, d2 = 0, fp = 0, isp = 0, usp = 0, sb = 0, lt = 0, imm = 0, lf = 32'h5c157d0f, ba, ex, pe;
   reg [255:0] gr = 0;
   wire [31:0] qd, ma, md, ea, ov;
   wire        qv, qt, mr, ack, busy, done, ill, inr, oimm;
   wire [2:0]  rn;
   integer     failures = 0, cmp_count = 0, p, m, i;
   always #10 clk = ~clk;
   // Next value of the shift register
   function automatic [31:0] rv();
      lf = {lf[30:0], ^(lf & 32'h80200003)};
      return lf;
   endfunction
   amead_decoder dut_u (.CLK(clk), .RST_B(rst_b), .START(start), .MODE(mode), .OPERAND_WRITTEN(ow),
      .FIRST_DISPLACEMENT(d1), .SECOND_DISPLACEMENT(d2), .GENERAL_REGS(gr), .FRAME_BASE_POINTER(fp),
      .INTERRUPT_STACK_POINTER(isp), .USER_STACK_POINTER(usp), .STATIC_BASE_POINTER(sb), .LINK_TABLE_BASE(lt),
      .PROCESSOR_STATUS_WORD(psw), .QUEUE_DATA(qd), .QUEUE_VALID(qv), .QUEUE_TAKE(qt), .MEM_REQ(mr),
      .MEM_ADDR(ma), .MEM_ACK(ack), .MEM_RDATA(md), .BUSY(busy), .DONE(done), .ILLEGAL_MODE(ill),
      .OPERAND_IN_REG(inr), .OPERAND_REG_NUM(rn), .OPERAND_IMMEDIATE(oimm), .OPERAND_VALUE(ov),
      .EFFECTIVE_ADDRESS(ea));
   amead_far far_u (.clk(clk), .rst_b(rst_b), .mem_req(mr), .slow(slow), .mem_addr(ma), .imm(imm),
      .mem_ack(ack), .queue_valid(qv), .mem_rdata(md), .queue_data(qd));
   task wrap_up;
      $display("comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Modes 0 to 22, read then written operand, fast then slow memory, back to back
   initial begin
      repeat (8) @(posedge clk);
      #1 rst_b = 1;
      for (p = 0; p < 2; p++) for (m = 0; m < 23; m++) begin
         d1 = rv(); d2 = rv(); fp = rv(); isp = rv(); usp = rv(); sb = rv(); lt = rv(); imm = rv();
         psw = rv();
         pe = ea;
         for (i = 0; i < 8; i++) gr[32*i +: 32] = rv();
         {start, mode, ow, slow} = {1'b1, m[4:0], p[0], 3'(3 * p)};
         @(posedge clk) #1 start = 0;
         for (i = 0; i < 40 && done !== 1'b1; i++) @(posedge clk) #1;
         if (i == 40) begin failures++; wrap_up; end
         // Pointer address: base plus first displacement; link entries are four bytes
         ba = (m == 16 ? fp : m == 17 ? (psw[9] ? usp : isp) : m == 18 ? sb : m == 22 ? lt + 3 * d1 : gr[32*(m%8) +: 32]) + d1;
         ex = (m >= 16 && m != 21) ? (ba ^ 32'h5a5a0f0f) + d2 : m == 21 ? d1 : ba;
         `CHK(ill, m == 19 || (m == 20 && p == 1))
         `CHK(inr, m < 8)
         if (m < 8) `CHK(rn, m[2:0])
         `CHK(oimm, (m == 20 && p == 0))
         if (m == 20 && p == 0) `CHK(ov, imm)
         // Modes without an address leave the last one standing
         `CHK(ea, ((m < 8 || m == 19 || m == 20) ? pe : ex))
         if ((m >= 16 && m <= 18) || m == 22) `CHK(ma, ba)
         `CHK(({busy, qt, mr}), 3'h0)
      end
      wrap_up;
   end
endmodule
